// ---- hw/rss_consts.svh ----
// offsets, field positions, reset values and counts for the rotate/subtract/sleep block
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// register map on the plain port: 00..7F are the file registers
`define RSS_ADDR_ACC        8'h80
`define RSS_ADDR_STATUS     8'h81
`define RSS_ADDR_WDOG       8'h82
`define RSS_FILE_TOP        8'h7F

// status field positions
`define RSS_ST_CARRY        0
`define RSS_ST_NIBBLE       1
`define RSS_ST_ZERO         2
`define RSS_ST_PWRDN_N      3
`define RSS_ST_EXP_N        4

// reset values
`define RSS_ACC_RST         8'h00
`define RSS_STATUS_RST      8'h18
`define RSS_WDOG_RST        8'h00

// watchdog prescaler and counter terminal counts
`define RSS_WDOG_PRESC_MAX  8'hFF
`define RSS_WDOG_COUNT_MAX  8'hFF

`endif

// ---- hw/rss_pkg.sv ----
// types for the rotate/subtract/sleep execution block
package rss_pkg;

  // instruction selector
  typedef enum logic [1:0] {
    RSS_OP_ROT_L = 2'h0,
    RSS_OP_ROT_R = 2'h1,
    RSS_OP_SUB   = 2'h2,
    RSS_OP_SLEEP = 2'h3
  } rss_op_type;

  // core run state, one-hot
  typedef enum logic [1:0] {
    RSS_RUN   = 2'b01,
    RSS_SLEEP = 2'b10
  } rss_state_type;

endpackage : rss_pkg

// ---- hw/rss_watchdog.sv ----
// watchdog counter with its prescaler
`timescale 1ns/100ps
`default_nettype none
`include "rss_consts.svh"

module rss_watchdog
  import rss_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       clear_i,
  output logic      [7:0] count_o,
  output logic            expiry_o
);

  logic [7:0] presc_reg;
  logic [7:0] presc_next;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic       expiry_reg;
  logic       expiry_next;
  logic       presc_wrap;

  ////////////////////////////////////////////////////////////////////////////
  // next values; clear beats the count so the sleep cycle never lets it tick
  always_comb begin
    presc_wrap  = (presc_reg == `RSS_WDOG_PRESC_MAX);
    presc_next  = presc_reg + 8'h01;
    count_next  = presc_wrap ? count_reg + 8'h01 : count_reg;
    expiry_next = presc_wrap && (count_reg == `RSS_WDOG_COUNT_MAX);
    if (clear_i) begin
      presc_next  = 8'h00;
      count_next  = 8'h00;
      expiry_next = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      presc_reg  <= 8'h00;
      count_reg  <= `RSS_WDOG_RST;
      expiry_reg <= 1'b0;
    end else begin
      presc_reg  <= presc_next;
      count_reg  <= count_next;
      expiry_reg <= expiry_next;
    end
  end

  assign count_o  = count_reg;
  assign expiry_o = expiry_reg;

  ////////////////////////////////////////////////////////////////////////////
  property p_wdog_clear;
    @(posedge clk_i) disable iff (!rst_b_i)
    clear_i |=> (count_reg == 8'h00) && (presc_reg == 8'h00) && !expiry_reg;
  endproperty
  a_wdog_clear: assert property (p_wdog_clear)
    else $error("watchdog not cleared");

endmodule : rss_watchdog
`default_nettype wire

// ---- hw/rss_exec.sv ----
// execution of rotate-through-link, literal subtract and sleep for an 8-bit core
//
// Function
// - left rotate: link into bit0, bit7 out
// - right rotate: link into bit7, bit0 out
// - destination clear: result to accumulator only
// - destination set: result back to file register
// - sleep clears powerdown flag, sets expiry flag
// - sleep clears watchdog counter and prescaler
// - sleep halts execution until wake-up
// - subtract: literal minus accumulator into accumulator
// - carry and nibble borrow from unsigned compares
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "rss_consts.svh"

module rss_exec
  import rss_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // instruction issue, same clock
  input  wire logic       op_valid_i,
  input  wire rss_op_type op_code_i,
  input  wire logic [6:0] file_addr_i,
  input  wire logic       dest_i,
  input  wire logic [7:0] literal_i,
  // wake-up request from outside the domain
  input  wire logic       wake_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rd_data_o,
  // state views
  output logic      [7:0] acc_o,
  output logic      [7:0] status_o,
  output logic            sleep_o
);

  logic [7:0]    file_mem [0:127];
  logic [7:0]    acc_reg;
  logic [7:0]    acc_next;
  logic [7:0]    status_reg;
  logic [7:0]    status_next;
  logic [7:0]    rd_data_reg;
  logic [7:0]    rd_data_next;
  rss_state_type state_reg;
  rss_state_type state_next;
  logic          wake_meta_reg;
  logic          wake_sync_reg;
  logic          op_go;
  logic [7:0]    file_rd;
  logic [7:0]    rot_result;
  logic          rot_link;
  logic [8:0]    sub_wide;
  logic [4:0]    nib_wide;
  logic          file_we;
  logic [6:0]    file_waddr;
  logic [7:0]    file_wdata;
  logic          wdog_clear;
  logic [7:0]    wdog_count;
  logic          wdog_expiry;

  ////////////////////////////////////////////////////////////////////////////
  // wake pin synchroniser; only the second stage is looked at
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
    end else begin
      wake_meta_reg <= wake_i;
      wake_sync_reg <= wake_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath: rotate and subtract results
  assign op_go   = op_valid_i && (state_reg == RSS_RUN);
  assign file_rd = file_mem[file_addr_i];

  always_comb begin
    if (op_code_i == RSS_OP_ROT_L) begin
      rot_result = {file_rd[6:0], status_reg[`RSS_ST_CARRY]};
      rot_link   = file_rd[7];
    end else begin
      rot_result = {status_reg[`RSS_ST_CARRY], file_rd[7:1]};
      rot_link   = file_rd[0];
    end
  end

  // extra top bit gives the borrow; it is inverted for the no-borrow sense
  assign sub_wide = {1'b0, literal_i} - {1'b0, acc_reg};
  assign nib_wide = {1'b0, literal_i[3:0]} - {1'b0, acc_reg[3:0]};

  ////////////////////////////////////////////////////////////////////////////
  // next state of accumulator, status, run state and file write
  always_comb begin
    acc_next    = acc_reg;
    status_next = status_reg;
    state_next  = state_reg;
    file_we     = 1'b0;
    file_waddr  = addr_i[6:0];
    file_wdata  = wr_data_i;
    wdog_clear  = 1'b0;
    // software writes first so an instruction in the same cycle wins
    if (wr_i) begin
      if (addr_i <= `RSS_FILE_TOP) begin
        file_we = 1'b1;
      end else if (addr_i == `RSS_ADDR_ACC) begin
        acc_next = wr_data_i;
      end else if (addr_i == `RSS_ADDR_STATUS) begin
        status_next = {3'h0, wr_data_i[4:0]};
      end
    end
    if (op_go) begin
      unique case (op_code_i)
        RSS_OP_ROT_L, RSS_OP_ROT_R: begin
          status_next[`RSS_ST_CARRY] = rot_link;
          if (dest_i) begin
            file_we    = 1'b1;
            file_waddr = file_addr_i;
            file_wdata = rot_result;
            if (wr_i && addr_i <= `RSS_FILE_TOP) begin
              file_we = 1'b1;                            // instruction write replaces bus write
            end
          end else begin
            acc_next = rot_result;
            if (wr_i && addr_i <= `RSS_FILE_TOP && addr_i[6:0] == file_addr_i) begin
              file_we = 1'b1;                            // bus write still lands
            end
          end
        end
        RSS_OP_SUB: begin
          acc_next                    = sub_wide[7:0];
          status_next[`RSS_ST_CARRY]  = ~sub_wide[8];
          status_next[`RSS_ST_NIBBLE] = ~nib_wide[4];
          status_next[`RSS_ST_ZERO]   = (sub_wide[7:0] == 8'h00);
        end
        RSS_OP_SLEEP: begin
          status_next[`RSS_ST_PWRDN_N] = 1'b0;
          status_next[`RSS_ST_EXP_N]   = 1'b1;
          wdog_clear                   = 1'b1;
          state_next                 = RSS_SLEEP;
        end
      endcase
    end
    // watchdog expiry marks a time-out; sleep clear in the same cycle wins
    if (wdog_expiry && !wdog_clear) begin
      status_next[`RSS_ST_EXP_N] = 1'b0;
    end
    // execution stays halted until a wake request or watchdog expiry
    if (state_reg == RSS_SLEEP && (wake_sync_reg || wdog_expiry)) begin
      state_next = RSS_RUN;
    end
  end

  // read data stands only in the cycle after the strobe
  always_comb begin
    rd_data_next = 8'h00;
    if (rd_i) begin
      if (addr_i <= `RSS_FILE_TOP) begin
        rd_data_next = file_mem[addr_i[6:0]];
      end else if (addr_i == `RSS_ADDR_ACC) begin
        rd_data_next = acc_reg;
      end else if (addr_i == `RSS_ADDR_STATUS) begin
        rd_data_next = status_reg;
      end else if (addr_i == `RSS_ADDR_WDOG) begin
        rd_data_next = wdog_count;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_reg     <= `RSS_ACC_RST;
      status_reg  <= `RSS_STATUS_RST;
      state_reg   <= RSS_RUN;
      rd_data_reg <= 8'h00;
    end else begin
      acc_reg     <= acc_next;
      status_reg  <= status_next;
      state_reg   <= state_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // file array has no reset; software must initialise it
  always_ff @(posedge clk_i) begin
    if (file_we) begin
      file_mem[file_waddr] <= file_wdata;
    end
  end

  rss_watchdog u_watchdog (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .clear_i  (wdog_clear),
    .count_o  (wdog_count),
    .expiry_o (wdog_expiry)
  );

  assign rd_data_o = rd_data_reg;
  assign acc_o     = acc_reg;
  assign status_o  = status_reg;
  assign sleep_o   = state_reg[1];               // one-hot sleep bit, straight from its flop

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_rot_left;
    @(posedge clk_i) disable iff (!rst_b_i)
    (op_go && op_code_i == RSS_OP_ROT_L && !dest_i) |=>
      (acc_reg == {$past(file_rd[6:0]), $past(status_reg[0])}) &&
      (status_reg[0] == $past(file_rd[7]));
  endproperty
  a_rot_left: assert property (p_rot_left)
    else $error("left rotate result wrong");

  property p_rot_right;
    @(posedge clk_i) disable iff (!rst_b_i)
    (op_go && op_code_i == RSS_OP_ROT_R && !dest_i) |=>
      (acc_reg == {$past(status_reg[0]), $past(file_rd[7:1])}) &&
      (status_reg[0] == $past(file_rd[0]));
  endproperty
  a_rot_right: assert property (p_rot_right)
    else $error("right rotate result wrong");

  property p_rot_flags;
    @(posedge clk_i) disable iff (!rst_b_i)
    (op_go && op_code_i inside {RSS_OP_ROT_L, RSS_OP_ROT_R} && !wr_i &&
     !wdog_expiry) |=>
      (status_reg[7:1] == $past(status_reg[7:1]));
  endproperty
  a_rot_flags: assert property (p_rot_flags)
    else $error("rotate touched other flags");

  property p_dest_acc;
    @(posedge clk_i) disable iff (!rst_b_i)
    (op_go && op_code_i inside {RSS_OP_ROT_L, RSS_OP_ROT_R} && !dest_i && !wr_i) |->
      !file_we;
  endproperty
  a_dest_acc: assert property (p_dest_acc)
    else $error("file written with destination clear");

  property p_dest_file;
    @(posedge clk_i) disable iff (!rst_b_i)
    (op_go && op_code_i inside {RSS_OP_ROT_L, RSS_OP_ROT_R} && dest_i) |->
      file_we && (file_waddr == file_addr_i) && (file_wdata == rot_result) ##1
      (acc_reg == $past(acc_reg) || $past(wr_i));
  endproperty
  a_dest_file: assert property (p_dest_file)
    else $error("rotate result not written back");

  property p_sleep_flags;
    @(posedge clk_i) disable iff (!rst_b_i)
    (op_go && op_code_i == RSS_OP_SLEEP) |=>
      !status_reg[`RSS_ST_PWRDN_N] && status_reg[`RSS_ST_EXP_N] && (wdog_count == 8'h00);
  endproperty
  a_sleep_flags: assert property (p_sleep_flags)
    else $error("sleep flags or watchdog wrong");

  property p_sleep_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
    (op_go && op_code_i == RSS_OP_SLEEP) ##1 (sleep_o && !wr_i) |=> $stable(acc_reg);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("execution continued in sleep");

  property p_sub_value;
    @(posedge clk_i) disable iff (!rst_b_i)
    (op_go && op_code_i == RSS_OP_SUB) |=>
      (acc_reg == $past(literal_i) - $past(acc_reg)) &&
      (status_reg[`RSS_ST_ZERO] == (acc_reg == 8'h00));
  endproperty
  a_sub_value: assert property (p_sub_value)
    else $error("subtract result or zero flag wrong");

  property p_sub_flags;
    @(posedge clk_i) disable iff (!rst_b_i)
    (op_go && op_code_i == RSS_OP_SUB) |=>
      (status_reg[`RSS_ST_CARRY] == ($past(acc_reg) <= $past(literal_i))) &&
      (status_reg[`RSS_ST_NIBBLE] == ($past(acc_reg[3:0]) <= $past(literal_i[3:0])));
  endproperty
  a_sub_flags: assert property (p_sub_flags)
    else $error("subtract carry or nibble flag wrong");

endmodule : rss_exec
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking testbench for the rotate/subtract/sleep execution block
`timescale 1ns/100ps
`default_nettype none
`include "rss_consts.svh"

module tb
  import rss_pkg::*;
;
  logic       clk_i;
  logic       rst_b_i;
  logic       op_valid_i;
  rss_op_type op_code_i;
  logic [6:0] file_addr_i;
  logic       dest_i;
  logic [7:0] literal_i;
  logic       wake_i;
  logic [7:0] addr_i;
  logic [7:0] wr_data_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rd_data_o;
  logic [7:0] acc_o;
  logic [7:0] status_o;
  logic       sleep_o;
  logic [7:0] rdv;
  int         n_mismatch;
  int         checks_done;

  rss_exec u_dut (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .op_valid_i  (op_valid_i),
    .op_code_i   (op_code_i),
    .file_addr_i (file_addr_i),
    .dest_i      (dest_i),
    .literal_i   (literal_i),
    .wake_i      (wake_i),
    .addr_i      (addr_i),
    .wr_data_i   (wr_data_i),
    .wr_i        (wr_i),
    .rd_i        (rd_i),
    .rd_data_o   (rd_data_o),
    .acc_o       (acc_o),
    .status_o    (status_o),
    .sleep_o     (sleep_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock, 10 ns period
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // common compare, case inequality so an unknown never matches a known value
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////////
  // register port: one-cycle strobes, read data in the following cycle only
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge clk_i);
    wr_i      <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 rdv = rd_data_o;
  endtask : bus_rd

  // one instruction, results visible after the taking edge
  task automatic op(input rss_op_type c, input logic [6:0] fa, input logic d,
                    input logic [7:0] lit);
    @(posedge clk_i);
    op_valid_i  <= 1'b1;
    op_code_i   <= c;
    file_addr_i <= fa;
    dest_i      <= d;
    literal_i   <= lit;
    @(posedge clk_i);
    op_valid_i  <= 1'b0;
    #1;
  endtask : op

  ////////////////////////////////////////////////////////////////////////////////
  // rotate case: nibble and zero preset to 1 to show they are left alone
  task automatic t_rot(input rss_op_type c, input logic [6:0] fa, input logic d,
                       input logic [7:0] fv, input logic cin,
                       input logic [7:0] res, input logic cout);
    bus_wr({1'b0, fa}, fv);
    bus_wr(`RSS_ADDR_ACC, 8'hA5);
    bus_wr(`RSS_ADDR_STATUS, {7'h0F, cin});
    op(c, fa, d, 8'h00);
    chk("rot status", status_o, {7'h0F, cout});
    chk("rot acc", acc_o, d ? 8'hA5 : res);
    bus_rd({1'b0, fa});
    chk("rot file", rdv, d ? res : fv);
  endtask : t_rot

  // literal minus accumulator with flags worked out here
  task automatic t_sub(input logic [7:0] lit, input logic [7:0] a);
    logic [7:0] r;
    r = lit - a;
    bus_wr(`RSS_ADDR_ACC, a);
    op(RSS_OP_SUB, 7'h00, 1'b0, lit);
    chk("sub acc", acc_o, r);
    chk("sub carry", {7'h00, status_o[0]}, {7'h00, a <= lit});
    chk("sub nibble", {7'h00, status_o[1]}, {7'h00, a[3:0] <= lit[3:0]});
    chk("sub zero", {7'h00, status_o[2]}, {7'h00, r == 8'h00});
  endtask : t_sub

  // sleep: flags, watchdog clear, halted issue, wake-up
  task automatic t_sleep();
    logic [7:0] a;
    int         n;
    bus_wr(`RSS_ADDR_STATUS, 8'h08);
    a = acc_o;
    op(RSS_OP_SLEEP, 7'h00, 1'b0, 8'h00);
    chk("sleep state", {7'h00, sleep_o}, 8'h01);
    chk("sleep flags", status_o, 8'h10);
    bus_rd(`RSS_ADDR_WDOG);
    chk("watchdog clear", rdv, 8'h00);
    // a prescaler left running would tick the counter within 256 cycles
    repeat (200) @(posedge clk_i);
    bus_rd(`RSS_ADDR_WDOG);
    chk("watchdog presc clear", rdv, 8'h00);
    op(RSS_OP_SUB, 7'h00, 1'b0, 8'h77);
    chk("no exec asleep", acc_o, a);
    @(posedge clk_i);
    wake_i <= 1'b1;
    n = 0;
    while (sleep_o === 1'b1 && n < 8) begin
      @(posedge clk_i);
      n++;
    end
    wake_i <= 1'b0;
    #1 chk("woken", {7'h00, sleep_o}, 8'h00);
  endtask : t_sleep

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    rst_b_i = 1'b0;
    op_valid_i = 1'b0;
    op_code_i = RSS_OP_ROT_L;
    file_addr_i = 7'h00;
    dest_i = 1'b0;
    literal_i = 8'h00;
    wake_i = 1'b0;
    addr_i = 8'h00;
    wr_data_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    #1;
    chk("reset acc", acc_o, `RSS_ACC_RST);
    chk("reset status", status_o, `RSS_STATUS_RST);
    bus_rd(8'hC3);
    chk("unmapped read", rdv, 8'h00);
    // status keeps only its five flag bits
    bus_wr(`RSS_ADDR_STATUS, 8'hFF);
    bus_rd(`RSS_ADDR_STATUS);
    chk("status write mask", rdv, 8'h1F);
    t_rot(RSS_OP_ROT_L, 7'h05, 1'b0, 8'hE6, 1'b0, 8'hCC, 1'b1);
    t_rot(RSS_OP_ROT_L, 7'h00, 1'b1, 8'h80, 1'b0, 8'h00, 1'b1);
    t_rot(RSS_OP_ROT_R, 7'h7F, 1'b1, 8'h02, 1'b1, 8'h81, 1'b0);
    t_rot(RSS_OP_ROT_R, 7'h7F, 1'b0, 8'h01, 1'b0, 8'h00, 1'b1);
    t_sub(8'h02, 8'h01);
    t_sub(8'h01, 8'h02);
    t_sub(8'h55, 8'h55);
    t_sub(8'h10, 8'h01);
    t_sub(8'hFF, 8'h00);
    t_sub(8'h00, 8'hFF);
    t_sleep();
    end_of_test();
  end

  // watchdog against a hang, far beyond the few hundred cycles needed
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end

endmodule : tb
`default_nettype wire
